//--- sspd_pkg.sv
// Package: constants, register map and field layout of the soft-strap default loader
// -----------------------------------------------------------------------------
// How it works
// RL1 - Port 1 speed strap, default one, is reset value of link speed-low bit.
// RL2 - Speed strap also seeds PHY rate-low bit and PHY mode field; 10BASE-T half is always advertised.
// RL3 - Duplex strap seeds Phy_fullhalf_bit, mode field, 10BASE-T full; default one.
// RL4 - Polarity strap seeds link duplex bit; in MII MAC mode sets duplex pin polarity.
// RL5 - Backpressure strap, default one, is reset value of port 1 backpressure enable.
// RL6 - Full-duplex pause strap, default one, seeds transmit and receive pause enables.
// RL7 - Full-duplex pause strap also seeds asymmetric pause advertisement bit.
// RL8 - Manual pause strap, default zero, seeds the manual pause select bit.
// RL9 - Manual pause strap also seeds asymmetric and symmetric pause advertisement.
// RL10 - Manual pause strap ignored in MII PHY, RMII PHY, MII MAC modes.
// RL11 - Port 2 auto-crossover strap is loaded into the hardware config state bit.
// RL12 - With strap control selected, crossover follows auto and manual crossover straps.
// RL13 - Strap control, auto strap low: manual zero forces MDI, one forces MDIX.
// RL14 - Digital reset or reload restores latched straps unless overridden; pins not resampled.
// RL15 - Final straps held in a register, applied in one cycle, mode qualified.
// -----------------------------------------------------------------------------
package sspd_pkg;

    // -------------------------------------------------------------------------
    // Strap vector layout
    // -------------------------------------------------------------------------
    localparam int STRAP_W        = 8;
    localparam int ST_SPEED       = 0;
    localparam int ST_DUPLEX      = 1;
    localparam int ST_DPOL        = 2;
    localparam int ST_BP          = 3;
    localparam int ST_FDFC        = 4;
    localparam int ST_MANFC       = 5;
    localparam int ST_AMDIX       = 6;
    localparam int ST_MDIX        = 7;
    // Defaults: speed 1, duplex 1, pol 0, bp 1, pause 1, manual 0, auto 1, mdix 0
    localparam logic [7:0] STRAP_DEFAULT = 8'h5b;

    // -------------------------------------------------------------------------
    // Port 1 interface select codes
    // -------------------------------------------------------------------------
    localparam logic [2:0] MODE_MII_MAC  = 3'h0;
    localparam logic [2:0] MODE_MII_PHY  = 3'h1;
    localparam logic [2:0] MODE_RMII_PHY = 3'h2;
    localparam logic [2:0] MODE_INT_PHY  = 3'h7;

    // -------------------------------------------------------------------------
    // Register offsets (byte addresses)
    // -------------------------------------------------------------------------
    localparam logic [7:0] OFS_LINK_BASIC = 8'h00;
    localparam logic [7:0] OFS_PHY_BASIC  = 8'h04;
    localparam logic [7:0] OFS_PHY_SPEC   = 8'h08;
    localparam logic [7:0] OFS_PHY_ADV    = 8'h0c;
    localparam logic [7:0] OFS_MAN_FC     = 8'h10;
    localparam logic [7:0] OFS_HARDWARE_CONFIG     = 8'h14;
    localparam logic [7:0] OFS_XOVER      = 8'h18;
    localparam logic [7:0] OFS_CMD        = 8'h1c;
    localparam logic [7:0] OFS_OVERRIDE   = 8'h20;

    // -------------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------------
    localparam int B_SPEED_LOW  = 13;   // link and PHY basic control
    localparam int B_DUPLEX     = 8;
    localparam int B_MODE_LSB   = 5;    // PHY special modes [7:5]
    localparam int B_ADV_ASYM   = 11;
    localparam int B_ADV_SYM    = 10;
    localparam int B_ADV_10FD   = 6;
    localparam int B_ADV_10HD   = 5;
    localparam int B_FC_TX      = 0;
    localparam int B_FC_RX      = 1;
    localparam int B_FC_MANUAL  = 2;
    localparam int B_FC_BP      = 3;
    localparam int B_HW_AMDIX   = 26;
    localparam int B_HW_DPOL    = 3;    // mode sits in [2:0]
    localparam int B_XO_SW_SEL  = 0;
    localparam int B_XO_SW_AUTO = 1;
    localparam int B_XO_SW_MDIX = 2;
    localparam int B_XO_AUTO_ST = 4;
    localparam int B_XO_MDIX_ST = 5;
    localparam int B_CMD_DRST   = 0;
    localparam int B_CMD_RELOAD = 1;
    localparam int B_OVR_VALID  = 8;

    // -------------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------------
    localparam int SYNC_STAGES   = 3;
    localparam int SETTLE_CYCLES = 4;   // sync depth plus one filter stage
    localparam int SETTLE_W      = 3;

endpackage : sspd_pkg

//--- sspd_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sspd_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         hardware_reset_pin_i,
    // Pin side
    input  wire logic [W-1:0] pin_i,
    // Synchronous side
    output logic      [W-1:0] val_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] val_q;
    logic [W-1:0] val_d;

    // -------------------------------------------------------------------------
    // Filter
    // -------------------------------------------------------------------------
    // A bit changes only once stages two and three agree; stage one feeds stage two only
    always_comb begin
        for (int i = 0; i < W; i++) begin
            val_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : val_q[i];
        end
    end

    // Stage registers
    always_ff @(posedge core_clk_i or negedge hardware_reset_pin_i) begin
        if (!hardware_reset_pin_i) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            val_q <= '0;
        end else begin
            s1_q  <= pin_i;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            val_q <= val_d;
        end
    end

    assign val_o = val_q;

endmodule : sspd_sync

//--- sspd_loader.sv
// Soft-strap default loader: latches straps, applies register defaults, APB slave
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module sspd_loader
    import sspd_pkg::*;
#(
    parameter logic [7:0] STRAP_DEF = STRAP_DEFAULT
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        hardware_reset_pin_i,
    // Strap pins
    input  wire logic [7:0]  strap_pins_i,
    input  wire logic [2:0]  port1_interface_select_i,
    // Port 1 duplex pin from the attached MAC
    input  wire logic        port1_fullhalf_pin_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Resulting configuration
    output logic             port1_full_duplex_o,
    output logic             port2_auto_crossover_o,
    output logic             port2_mdix_o,
    output logic             strap_done_o
);

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction : merge

    function automatic logic mii_like(input logic [2:0] mode);
        return (mode == MODE_MII_PHY) || (mode == MODE_RMII_PHY) || (mode == MODE_MII_MAC);
    endfunction : mii_like

    // -------------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------------
    logic [7:0] strap_sync;
    logic [2:0] mode_sync;
    logic       dpin_sync;

    sspd_sync #(.W(12)) u_sync_straps (
        .core_clk_i (core_clk_i),
        .hardware_reset_pin_i     (hardware_reset_pin_i),
        .pin_i      ({port1_interface_select_i, port1_fullhalf_pin_i, strap_pins_i}),
        .val_o      ({mode_sync, dpin_sync, strap_sync})
    );

    // -------------------------------------------------------------------------
    // Latch sequencing
    // -------------------------------------------------------------------------
    logic [SETTLE_W-1:0]  settle_q, settle_d;
    logic                 done_q, done_d;
    logic [STRAP_W-1:0]   latched_q, latched_d;
    logic [2:0]           mode_q, mode_d;
    logic [STRAP_W-1:0]   ovr_q, ovr_d;
    logic                 ovr_valid_q, ovr_valid_d;
    logic [STRAP_W-1:0]   final_q, final_d;
    logic                 apply_q, apply_d;

    // APB decode shared with the register group
    logic        acc;
    logic        wr_en;
    logic [31:0] cmd_wr;
    logic [31:0] ovr_wv;

    assign acc    = psel_i && penable_i && pready_o;
    assign wr_en  = acc && pwrite_i;
    assign cmd_wr = (wr_en && paddr_i == OFS_CMD) ? merge(32'h0, pwdata_i, pstrb_i) : 32'h0;
    assign ovr_wv = merge({23'h0, ovr_valid_q, ovr_q}, pwdata_i, pstrb_i);

    // Pins are sampled once after reset release; later reloads never resample them
    always_comb begin
        settle_d    = settle_q;
        done_d      = done_q;
        latched_d   = latched_q;
        mode_d      = mode_q;
        ovr_d       = ovr_q;
        ovr_valid_d = ovr_valid_q;
        final_d     = final_q;
        apply_d     = 1'b0;
        if (!done_q) begin
            // Filter output first holds the pins after SETTLE_CYCLES edges; latch on the next
            if (settle_q == SETTLE_W'(SETTLE_CYCLES)) begin
                latched_d = strap_sync;
                mode_d    = mode_sync;
                final_d   = strap_sync;
                done_d    = 1'b1;
                apply_d   = 1'b1;
            end else begin
                settle_d = settle_q + SETTLE_W'(1);
            end
        end
        if (wr_en && paddr_i == OFS_OVERRIDE) begin
            ovr_d       = ovr_wv[7:0];
            ovr_valid_d = ovr_wv[B_OVR_VALID];
        end
        if (done_q && (cmd_wr[B_CMD_DRST] || cmd_wr[B_CMD_RELOAD])) begin
            final_d = ovr_valid_q ? ovr_q : latched_q;          // [RL14]
            apply_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge hardware_reset_pin_i) begin
        if (!hardware_reset_pin_i) begin
            settle_q    <= '0;
            done_q      <= 1'b0;
            latched_q   <= STRAP_DEFAULT;
            mode_q      <= MODE_INT_PHY;
            ovr_q       <= '0;
            ovr_valid_q <= 1'b0;
            final_q     <= STRAP_DEFAULT;                    // [RL15]
            apply_q     <= 1'b0;
        end else begin
            settle_q    <= settle_d;
            done_q      <= done_d;
            latched_q   <= latched_d;
            mode_q      <= mode_d;
            ovr_q       <= ovr_d;
            ovr_valid_q <= ovr_valid_d;
            final_q     <= final_d;
            apply_q     <= apply_d;
        end
    end

    // -------------------------------------------------------------------------
    // Derived defaults from the final straps
    // -------------------------------------------------------------------------
    logic manfc_eff;
    logic dft_speed, dft_duplex, dft_dpol;
    logic [2:0] dft_mode;

    // Manual pause strap means nothing when port 1 faces an external MAC or PHY
    assign manfc_eff  = final_q[ST_MANFC] && !mii_like(mode_q);       // [RL10]
    assign dft_speed  = final_q[ST_SPEED];
    assign dft_duplex = final_q[ST_DUPLEX];
    assign dft_dpol   = final_q[ST_DPOL];
    // Forced-mode code: speed and duplex pick one of the fixed modes
    assign dft_mode   = {1'b0, dft_speed, dft_duplex};                // [RL2] [RL3]

    // -------------------------------------------------------------------------
    // Configuration registers
    // -------------------------------------------------------------------------
    logic [1:0] link_q, link_d;         // {speed_low, duplex}
    logic [1:0] phyb_q, phyb_d;         // {rate_low, fullhalf}
    logic [2:0] phym_q, phym_d;
    logic [3:0] adv_q, adv_d;           // {asym, sym, 10fd, 10hd}
    logic [3:0] fc_q, fc_d;             // {bp, manual, rx, tx}
    logic       amdix_st_q, amdix_st_d;
    logic [2:0] xo_q, xo_d;             // {sw_mdix, sw_auto, sw_sel}
    logic [31:0] wv;

    // Software writes land on the accessed register; an apply pulse reloads every strap-derived default, not the crossover select
    always_comb begin
        link_d     = link_q;
        phyb_d     = phyb_q;
        phym_d     = phym_q;
        adv_d      = adv_q;
        fc_d       = fc_q;
        amdix_st_d = amdix_st_q;
        xo_d       = xo_q;
        wv         = 32'h0;
        if (apply_q) begin
            link_d     = {dft_speed, dft_dpol};                       // [RL1] [RL4]
            phyb_d     = {dft_speed, dft_duplex};                     // [RL2] [RL3]
            phym_d     = dft_mode;
            adv_d[3]   = final_q[ST_FDFC] && !manfc_eff;              // [RL7] [RL9]
            adv_d[2]   = final_q[ST_FDFC] && !manfc_eff;              // [RL9]
            adv_d[1]   = dft_duplex;                                  // [RL3]
            adv_d[0]   = 1'b1;
            fc_d       = {final_q[ST_BP], manfc_eff,
                          final_q[ST_FDFC], final_q[ST_FDFC]};        // [RL5] [RL6] [RL8]
            amdix_st_d = final_q[ST_AMDIX];                           // [RL11]
        end else if (wr_en) begin
            unique case (paddr_i)
                OFS_LINK_BASIC: begin
                    wv     = merge({18'h0, link_q[1], 4'h0, link_q[0], 8'h0}, pwdata_i, pstrb_i);
                    link_d = {wv[B_SPEED_LOW], wv[B_DUPLEX]};
                end
                OFS_PHY_BASIC: begin
                    wv     = merge({18'h0, phyb_q[1], 4'h0, phyb_q[0], 8'h0}, pwdata_i, pstrb_i);
                    phyb_d = {wv[B_SPEED_LOW], wv[B_DUPLEX]};
                end
                OFS_PHY_SPEC: begin
                    wv     = merge({24'h0, phym_q, 5'h0}, pwdata_i, pstrb_i);
                    phym_d = wv[B_MODE_LSB +: 3];
                end
                OFS_PHY_ADV: begin
                    wv    = merge({20'h0, adv_q[3:2], 3'h0, adv_q[1:0], 5'h0}, pwdata_i, pstrb_i);
                    adv_d = {wv[B_ADV_ASYM], wv[B_ADV_SYM], wv[B_ADV_10FD], wv[B_ADV_10HD]};
                end
                OFS_MAN_FC: begin
                    wv   = merge({28'h0, fc_q}, pwdata_i, pstrb_i);
                    fc_d = {wv[B_FC_BP], wv[B_FC_MANUAL], wv[B_FC_RX], wv[B_FC_TX]};
                end
                OFS_XOVER: begin
                    wv   = merge({29'h0, xo_q}, pwdata_i, pstrb_i);
                    xo_d = {wv[B_XO_SW_MDIX], wv[B_XO_SW_AUTO], wv[B_XO_SW_SEL]};
                end
                default: begin
                    wv = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge hardware_reset_pin_i) begin
        if (!hardware_reset_pin_i) begin
            link_q     <= {STRAP_DEFAULT[ST_SPEED], STRAP_DEFAULT[ST_DPOL]};
            phyb_q     <= {STRAP_DEFAULT[ST_SPEED], STRAP_DEFAULT[ST_DUPLEX]};
            phym_q     <= {1'b0, STRAP_DEFAULT[ST_SPEED], STRAP_DEFAULT[ST_DUPLEX]};
            adv_q      <= {STRAP_DEFAULT[ST_FDFC], STRAP_DEFAULT[ST_FDFC], STRAP_DEFAULT[ST_DUPLEX], 1'b1};
            fc_q       <= {STRAP_DEFAULT[ST_BP], STRAP_DEFAULT[ST_MANFC],
                           STRAP_DEFAULT[ST_FDFC], STRAP_DEFAULT[ST_FDFC]};
            amdix_st_q <= STRAP_DEFAULT[ST_AMDIX];
            xo_q       <= 3'h0;     // Straps steer crossover by default
        end else begin
            link_q     <= link_d;
            phyb_q     <= phyb_d;
            phym_q     <= phym_d;
            adv_q      <= adv_d;
            fc_q       <= fc_d;
            amdix_st_q <= amdix_st_d;
            xo_q       <= xo_d;
        end
    end

    // -------------------------------------------------------------------------
    // Outputs: crossover and duplex pin
    // -------------------------------------------------------------------------
    logic auto_q, auto_d, mdix_q, mdix_d, fdx_q, fdx_d;

    // Strap control: auto strap wins; otherwise manual strap picks MDI or MDIX
    always_comb begin
        if (!xo_q[0]) begin
            auto_d = final_q[ST_AMDIX];                               // [RL12]
            mdix_d = !final_q[ST_AMDIX] && final_q[ST_MDIX];          // [RL13]
        end else begin
            auto_d = xo_q[1];
            mdix_d = !xo_q[1] && xo_q[2];
        end
        // Polarity applies only in MII MAC mode; elsewhere the link register decides
        if (mode_q == MODE_MII_MAC) begin
            fdx_d = (dpin_sync == dft_dpol);                          // [RL4]
        end else begin
            fdx_d = link_q[0];
        end
    end

    always_ff @(posedge core_clk_i or negedge hardware_reset_pin_i) begin
        if (!hardware_reset_pin_i) begin
            auto_q <= 1'b0;
            mdix_q <= 1'b0;
            fdx_q  <= 1'b0;
        end else begin
            auto_q <= auto_d;
            mdix_q <= mdix_d;
            fdx_q  <= fdx_d;
        end
    end

    // -------------------------------------------------------------------------
    // APB slave: one wait state, registered answer
    // -------------------------------------------------------------------------
    logic [31:0] rd_d, rd_q;
    logic        rdy_d, rdy_q, err_d, err_q;

    always_comb begin
        rdy_d = psel_i && penable_i && !rdy_q;
        rd_d  = 32'h0;
        err_d = 1'b0;
        if (rdy_d) begin
            unique case (paddr_i)
                OFS_LINK_BASIC: rd_d = {18'h0, link_q[1], 4'h0, link_q[0], 8'h0};
                OFS_PHY_BASIC:  rd_d = {18'h0, phyb_q[1], 4'h0, phyb_q[0], 8'h0};
                OFS_PHY_SPEC:   rd_d = {24'h0, phym_q, 5'h0};
                OFS_PHY_ADV:    rd_d = {20'h0, adv_q[3:2], 3'h0, adv_q[1:0], 5'h0};
                OFS_MAN_FC:     rd_d = {28'h0, fc_q};
                OFS_HARDWARE_CONFIG:     rd_d = {5'h0, amdix_st_q, 22'h0, dft_dpol, mode_q};
                OFS_XOVER:      rd_d = {26'h0, mdix_q, auto_q, 1'b0, xo_q};
                OFS_CMD:        rd_d = 32'h0;
                OFS_OVERRIDE:   rd_d = {23'h0, ovr_valid_q, ovr_q};
                default:        err_d = 1'b1;   // Unmapped: error, data zero
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge hardware_reset_pin_i) begin
        if (!hardware_reset_pin_i) begin
            rdy_q <= 1'b0;
            rd_q  <= 32'h0;
            err_q <= 1'b0;
        end else begin
            rdy_q <= rdy_d;
            rd_q  <= rd_d;
            err_q <= err_d;
        end
    end

    assign prdata_o               = rd_q;
    assign pready_o               = rdy_q;
    assign pslverr_o              = err_q;
    assign port1_full_duplex_o    = fdx_q;
    assign port2_auto_crossover_o = auto_q;
    assign port2_mdix_o           = mdix_q;
    assign strap_done_o           = done_q;

endmodule : sspd_loader

//--- sspd_loader_sva.sv
// Checker: APB handshake, strap timing and latch stability of the loader
`timescale 1ns/1ps
module sspd_loader_sva (
    // Clock and reset
    input wire logic        core_clk_i,
    input wire logic        hardware_reset_pin_i,
    // APB
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Strap results
    input wire logic        port2_auto_crossover_o,
    input wire logic        strap_done_o
);
    logic [2:0] cnt_d;
    logic [2:0] cnt_q;

    // ------------------------------------------------------------------
    // Cycles since reset release, saturating
    // ------------------------------------------------------------------
    always_comb cnt_d = (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
    always_ff @(posedge core_clk_i or negedge hardware_reset_pin_i) begin
        if (!hardware_reset_pin_i) cnt_q <= 3'h0;
        else cnt_q <= cnt_d;
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!hardware_reset_pin_i);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_ready_once: assert property (pready_o |=> !pready_o) else $error("pready longer than one cycle");
    a_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("no answer one cycle after access");
    a_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i))
        else $error("pready without access");
    a_err_paired: assert property (pslverr_o |-> pready_o) else $error("error without pready");
    a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data outside answer");
    a_done_time: assert property (strap_done_o == (cnt_q >= 3'h5)) else $error("strap latch timing");
    a_done_holds: assert property (strap_done_o |=> strap_done_o) else $error("strap done dropped");
    // Pins changing later must not reach the output without a command
    a_no_resample: assert property (cnt_q == 3'h7 && !$past(psel_i) && !$past(psel_i, 2) && !$past(psel_i, 3)
        && !$past(psel_i, 4) |-> $stable(port2_auto_crossover_o)) else $error("crossover moved without command");
endmodule : sspd_loader_sva

bind sspd_loader sspd_loader_sva u_sva (.core_clk_i(core_clk_i), .hardware_reset_pin_i(hardware_reset_pin_i), .psel_i(psel_i),
    .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .port2_auto_crossover_o(port2_auto_crossover_o), .strap_done_o(strap_done_o));

//--- tb_soft_strap_port_defaults.sv
// Testbench: strap defaults, mode qualification and reload of the loader
`timescale 1ns/1ps
module tb_soft_strap_port_defaults;
    import sspd_pkg::*;
    logic        clk  = 1'b0;
    logic        hardware_reset_pin = 1'b0;
    logic [7:0]  pins = STRAP_DEFAULT;
    logic [2:0]  mode = MODE_INT_PHY;
    logic        fhp  = 1'b0;
    logic        psel = 1'b0;
    logic        pen  = 1'b0;
    logic        pwr  = 1'b0;
    logic [7:0]  pad  = 8'h00;
    logic [31:0] pwd  = 32'h0;
    logic [31:0] prd;
    logic        prdy, perr, fd, xauto, xmdix, done;
    int          miscompares = 0;
    int          tests_run   = 0;
    int          cycles      = 0;
    logic [7:0]  pl [4] = '{8'h3f, 8'h3b, 8'h3f, 8'h3f};
    logic [2:0]  ml [4] = '{MODE_MII_MAC, MODE_MII_MAC, MODE_MII_PHY, MODE_RMII_PHY};

    always #10 clk = ~clk;

    sspd_loader dut (.core_clk_i(clk), .hardware_reset_pin_i(hardware_reset_pin), .strap_pins_i(pins), .port1_interface_select_i(mode),
        .port1_fullhalf_pin_i(fhp), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pad),
        .pwdata_i(pwd), .pstrb_i(4'hf), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
        .port1_full_duplex_o(fd), .port2_auto_crossover_o(xauto), .port2_mdix_o(xmdix), .strap_done_o(done));

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            miscompares = miscompares + 1;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr  <= w;
        pad  <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk("pready", 32'h1, {31'h0, prdy});
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
    endtask : wr

    task automatic rdm(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(nm, e, rd & m);
    endtask : rdm

    // Reset with given pins; latch settles well inside ten cycles
    task automatic boot(input logic [7:0] p, input logic [2:0] md, input logic fp);
        hardware_reset_pin <= 1'b0;
        pins <= p;
        mode <= md;
        fhp  <= fp;
        repeat (16) @(posedge clk);
        hardware_reset_pin <= 1'b1;
        repeat (10) @(posedge clk);
        chk("strap done", 32'h1, {31'h0, done});
    endtask : boot

    // All register defaults and outputs expected from strap set s
    task automatic regs(input string nm, input logic [7:0] s, input logic [2:0] md);
        logic man;
        logic pz;
        man = (md == MODE_INT_PHY) ? s[ST_MANFC] : 1'b0;
        pz  = s[ST_FDFC] & ~man;
        rdm("link basic", OFS_LINK_BASIC, 32'h2100, {18'h0, s[0], 4'h0, s[2], 8'h0});
        rdm("phy basic", OFS_PHY_BASIC, 32'h2100, {18'h0, s[0], 4'h0, s[1], 8'h0});
        rdm("phy mode", OFS_PHY_SPEC, 32'he0, {24'h0, 1'b0, s[0], s[1], 5'h0});
        rdm("advert", OFS_PHY_ADV, 32'hc60, {20'h0, pz, pz, 3'h0, s[1], 1'b1, 5'h0});
        rdm("pause ctrl", OFS_MAN_FC, 32'hf, {28'h0, s[3], man, s[4], s[4]});
        rdm("hw config", OFS_HARDWARE_CONFIG, 32'h0400000f, {5'h0, s[6], 22'h0, s[2], md});
        rdm("crossover", OFS_XOVER, s[6] ? 32'h11 : 32'h31, {26'h0, ~s[6] & s[7], s[6], 4'h0});
        chk("auto port", {31'h0, s[6]}, {31'h0, xauto});
        if (!s[6]) chk("mdix port", {31'h0, s[7]}, {31'h0, xmdix});
        chk("duplex port", {31'h0, (md == MODE_MII_MAC) ? (fhp == s[2]) : s[2]}, {31'h0, fd});
        $display("test %s done", nm);
    endtask : regs

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        logic        er;
        boot(STRAP_DEFAULT, MODE_INT_PHY, 1'b0);
        regs("defaults", STRAP_DEFAULT, MODE_INT_PHY);
        boot(8'ha4, MODE_INT_PHY, 1'b0);
        regs("strapped mdix", 8'ha4, MODE_INT_PHY);
        // Host modes drop the manual pause strap
        for (int i = 0; i < 4; i++) begin
            boot(pl[i], ml[i], 1'b1);
            regs("host mode", pl[i], ml[i]);
        end
        // Reload keeps latched values although pins moved
        boot(8'h24, MODE_INT_PHY, 1'b0);
        pins <= 8'hdb;
        wr(OFS_CMD, 32'h2);
        repeat (4) @(posedge clk);
        regs("reload", 8'h24, MODE_INT_PHY);
        wr(OFS_OVERRIDE, 32'h180);
        wr(OFS_CMD, 32'h1);
        repeat (4) @(posedge clk);
        regs("override", 8'h80, MODE_INT_PHY);
        // Refused accesses and software crossover select
        apb(1'b0, 8'h24, 32'h0, rd, er);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        wr(OFS_HARDWARE_CONFIG, 32'hffffffff);
        rdm("hw read only", OFS_HARDWARE_CONFIG, 32'h0400000f, 32'h7);
        wr(OFS_XOVER, 32'h1);
        repeat (3) @(posedge clk);
        chk("sw mdi", 32'h0, {31'h0, xmdix});
        wr(OFS_XOVER, 32'h3);
        repeat (3) @(posedge clk);
        chk("sw auto", 32'h1, {31'h0, xauto});
        $display("test refused done");
        report_and_stop();
    end
endmodule : tb_soft_strap_port_defaults
